// ### design/dcc_axil_slave.sv
// axi4-lite slave front end for the core control register
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"
module dcc_axil_slave
  import dcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output dcc_wr_s wr_req,
  input wire logic [15:0] rd_word
);
  dcc_wst_e st_ff;
  logic aw_got_ff, w_got_ff, rvalid_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic aw_now, w_now, have_aw, have_w, ar_now;
  logic [3:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  assign s_awready = (st_ff == DCC_W_COLLECT) && !aw_got_ff;
  assign s_wready = (st_ff == DCC_W_COLLECT) && !w_got_ff;
  assign s_bvalid = (st_ff == DCC_W_RESP);
  assign s_bresp = bresp_ff;
  assign aw_now = s_awvalid && s_awready;
  assign w_now = s_wvalid && s_wready;
  assign have_aw = aw_got_ff || aw_now;
  assign have_w = w_got_ff || w_now;
  assign wa = aw_got_ff ? awaddr_ff : s_awaddr;
  assign wd = w_got_ff ? wdata_ff : s_wdata;
  assign ws = w_got_ff ? wstrb_ff : s_wstrb;
  // write lands in the cycle both halves are present
  assign wr_en = (st_ff == DCC_W_COLLECT) && have_aw && have_w
    && dcc_hit(wa);
  assign wr_req = '{data: wd[15:0], strb: ws[1:0]};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_ff <= DCC_W_COLLECT;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bresp_ff <= `DCC_RESP_OKAY;
    end else begin
      case (st_ff)
        DCC_W_COLLECT: begin
          if (have_aw && have_w) begin
            st_ff <= DCC_W_RESP;
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bresp_ff <= dcc_hit(wa) ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
          end else begin
            aw_got_ff <= have_aw;
            w_got_ff <= have_w;
          end
        end
        DCC_W_RESP: begin
          if (s_bready) begin
            st_ff <= DCC_W_COLLECT;
          end
        end
        default: begin
          st_ff <= DCC_W_COLLECT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      if (aw_now) begin
        awaddr_ff <= s_awaddr;
      end
      if (w_now) begin
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end
    end
  end

  assign s_arready = !rvalid_ff;
  assign ar_now = s_arvalid && s_arready;
  assign s_rvalid = rvalid_ff;
  assign s_rdata = rdata_ff;
  assign s_rresp = rresp_ff;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `DCC_RESP_OKAY;
    end else if (ar_now) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= dcc_hit(s_araddr) ? {16'h0, rd_word} : 32'h0;
      rresp_ff <= dcc_hit(s_araddr) ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
    end else if (s_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
endmodule // dcc_axil_slave
`default_nettype wire

// ### design/dcc_core_ctrl.sv
// dsp core control register with axi4-lite access
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"
module dcc_core_ctrl
  import dcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic loop_start,
  input wire logic loop_finish,
  input wire logic loop_iter_end,
  input wire logic prio_top_set,
  input wire logic [2:0] prio_low_bits,
  input wire logic stack_frame_active,
  output dcc_ctrl_s ctrl,
  output logic [3:0] cpu_prio_level,
  output logic [2:0] loop_depth,
  output logic loop_early_end,
  output logic loop_cut
);
  logic wr_en;
  dcc_wr_s wr_req;
  logic [15:0] rd_word;
  logic lo_wr, hi_wr, early_req;
  logic var_lat_ff;
  logic [1:0] mult_sign_sel_ff;
  logic acc_a_sat_en_ff;
  logic acc_b_sat_en_ff;
  logic space_write_sat_en_ff;
  logic sat_mode_sel_ff;
  logic prio_top_bit_ff;
  logic rounding_sel_ff;
  logic int_frac_sel_ff;

  dcc_axil_slave u_bus (
    .clk_sys(clk_sys),
    .reset(reset),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_req(wr_req),
    .rd_word(rd_word)
  );

  dcc_loop_tracker u_loop (
    .clk_sys(clk_sys),
    .reset(reset),
    .loop_start(loop_start),
    .loop_finish(loop_finish),
    .loop_iter_end(loop_iter_end),
    .early_req(early_req),
    .loop_depth(loop_depth),
    .early_pending(loop_early_end),
    .loop_cut(loop_cut)
  );

  // byte lanes of the 16-bit register
  assign lo_wr = wr_en && wr_req.strb[0];
  assign hi_wr = wr_en && wr_req.strb[1];
  // trigger only, never stored
  assign early_req = hi_wr && wr_req.data[`DCC_EARLY_BIT];

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      var_lat_ff <= 1'b0;
    end else if (hi_wr) begin
      var_lat_ff <= wr_req.data[`DCC_VAR_LAT_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mult_sign_sel_ff <= `DCC_MSIGN_SIGNED;
    end else if (hi_wr) begin
      mult_sign_sel_ff <=
        wr_req.data[`DCC_MSIGN_HI:`DCC_MSIGN_LO];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc_a_sat_en_ff <= 1'b0;
      acc_b_sat_en_ff <= 1'b0;
      space_write_sat_en_ff <= 1'b1;
      sat_mode_sel_ff <= 1'b0;
      rounding_sel_ff <= 1'b0;
      int_frac_sel_ff <= 1'b0;
    end else if (lo_wr) begin
      acc_a_sat_en_ff <= wr_req.data[`DCC_ACCUMULATOR_A_BIT];
      acc_b_sat_en_ff <= wr_req.data[`DCC_ACCUMULATOR_B_BIT];
      space_write_sat_en_ff <= wr_req.data[`DCC_SDW_BIT];
      sat_mode_sel_ff <= wr_req.data[`DCC_SATM_BIT];
      rounding_sel_ff <= wr_req.data[`DCC_RND_BIT];
      int_frac_sel_ff <= wr_req.data[`DCC_FRAC_BIT];
    end
  end

  // core raises it, software may only clear it; a raise wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prio_top_bit_ff <= 1'b0;
    end else if (prio_top_set) begin
      prio_top_bit_ff <= 1'b1;
    end else if (lo_wr && !wr_req.data[`DCC_PRIO_BIT]) begin
      prio_top_bit_ff <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 16'h0;
    rd_word[`DCC_VAR_LAT_BIT] = var_lat_ff;
    rd_word[`DCC_MSIGN_HI:`DCC_MSIGN_LO] = mult_sign_sel_ff;
    rd_word[`DCC_EARLY_BIT] = 1'b0;
    rd_word[`DCC_DEPTH_HI:`DCC_DEPTH_LO] = loop_depth;
    rd_word[`DCC_ACCUMULATOR_A_BIT] = acc_a_sat_en_ff;
    rd_word[`DCC_ACCUMULATOR_B_BIT] = acc_b_sat_en_ff;
    rd_word[`DCC_SDW_BIT] = space_write_sat_en_ff;
    rd_word[`DCC_SATM_BIT] = sat_mode_sel_ff;
    rd_word[`DCC_PRIO_BIT] = prio_top_bit_ff;
    rd_word[`DCC_SFA_BIT] = stack_frame_active;
    rd_word[`DCC_RND_BIT] = rounding_sel_ff;
    rd_word[`DCC_FRAC_BIT] = int_frac_sel_ff;
  end

  assign ctrl.var_latency = var_lat_ff;
  // only code 01 asks for unsigned operands
  assign ctrl.mult_unsigned =
    mult_sign_sel_ff == `DCC_MSIGN_UNSIGNED;
  assign ctrl.acc_a_sat_en = acc_a_sat_en_ff;
  assign ctrl.acc_b_sat_en = acc_b_sat_en_ff;
  assign ctrl.space_write_sat_en = space_write_sat_en_ff;
  assign ctrl.sat_mode_sel = sat_mode_sel_ff;
  assign ctrl.rounding_sel = rounding_sel_ff;
  assign ctrl.int_frac_sel = int_frac_sel_ff;
  assign cpu_prio_level = {prio_top_bit_ff, prio_low_bits};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // register field checks
  a_var_lat_follow: assert property (
    hi_wr |=> ctrl.var_latency == $past(wr_req.data[15]))
    else $error("variable latency bit did not follow write");

  a_reset_values: assert property (
    $past(reset) |-> !ctrl.var_latency && !ctrl.mult_unsigned
      && !ctrl.acc_a_sat_en && !ctrl.acc_b_sat_en
      && ctrl.space_write_sat_en && !ctrl.sat_mode_sel
      && cpu_prio_level[3] == 1'b0)
    else $error("control fields wrong after reset");

  a_mult_sign_code: assert property (
    hi_wr ##1 !hi_wr |-> ctrl.mult_unsigned ==
      ($past(wr_req.data[13:12]) == 2'h1))
    else $error("multiplier signedness does not match code");

  a_depth_read: assert property (
    loop_start && !loop_finish && !loop_cut && loop_depth != 3'h7
      |=> rd_word[10:8] == $past(loop_depth) + 3'h1)
    else $error("loop depth did not count up");

  a_depth_ceiling: assert property (
    loop_depth == 3'h7 && !loop_finish && !loop_cut
      |=> loop_depth == 3'h7)
    else $error("loop depth wrapped past seven");

  a_acc_a_write: assert property (
    lo_wr |=> ctrl.acc_a_sat_en == $past(wr_req.data[7])
      && ctrl.acc_b_sat_en == $past(wr_req.data[6]))
    else $error("accumulator saturation enables wrong");

  a_acc_b_hold: assert property (
    !lo_wr |=> $stable(ctrl.acc_b_sat_en)
      && $stable(ctrl.acc_a_sat_en))
    else $error("accumulator enable changed without write");

  a_sdw_write: assert property (
    lo_wr |=> ctrl.space_write_sat_en == $past(wr_req.data[5])
      && rd_word[5] == ctrl.space_write_sat_en)
    else $error("data write saturation enable wrong");

  a_sat_mode: assert property (
    lo_wr |=> rd_word[4] == ctrl.sat_mode_sel
      && ctrl.sat_mode_sel == $past(wr_req.data[4]))
    else $error("saturation mode not taken");

  a_prio_set_wins: assert property (
    prio_top_set |=> cpu_prio_level[3] && rd_word[3])
    else $error("priority top bit lost a raise");

  a_prio_clear: assert property (
    lo_wr && !wr_req.data[3] && !prio_top_set
      |=> !cpu_prio_level[3])
    else $error("priority top bit not cleared");

  a_prio_concat: assert property (
    cpu_prio_level[2:0] == prio_low_bits)
    else $error("priority low bits not passed through");

  a_early_cut: assert property (
    loop_early_end && loop_iter_end && !early_req && !loop_start
      && !loop_finish && loop_depth != 3'h0
      |=> loop_depth == $past(loop_depth) - 3'h1 && !loop_early_end)
    else $error("early end did not close the loop");

  a_early_zero: assert property (
    s_rvalid |-> s_rdata[11] == 1'b0)
    else $error("early end bit read back as one");

  a_unused_zero: assert property (
    s_rvalid |-> s_rdata[14] == 1'b0 && s_rdata[31:16] == 16'h0)
    else $error("unimplemented bits read nonzero");

  a_depth_ro: assert property (
    hi_wr && !loop_start && !loop_finish && !loop_cut
      |=> $stable(loop_depth))
    else $error("software write changed loop depth");

  a_var_lat_hold: assert property (
    !hi_wr |=> $stable(ctrl.var_latency))
    else $error("variable latency bit changed without write");

  a_sign_hold: assert property (
    !hi_wr |=> $stable(mult_sign_sel_ff))
    else $error("multiplier sign field changed without write");

  a_sdw_hold: assert property (
    !lo_wr |=> $stable(ctrl.space_write_sat_en)
      && $stable(ctrl.sat_mode_sel))
    else $error("saturation control changed without write");

  a_prio_hold: assert property (
    !prio_top_set && !lo_wr |=> $stable(cpu_prio_level[3]))
    else $error("priority top bit changed on its own");

  // loop depth and early end checks
  a_depth_floor: assert property (
    loop_depth == 3'h0 && !loop_start |=> loop_depth == 3'h0)
    else $error("loop depth went below zero");

  a_depth_down: assert property (
    loop_finish && !loop_start && loop_depth != 3'h0
      |=> loop_depth == $past(loop_depth) - 3'h1)
    else $error("loop depth did not count down");

  a_early_arm: assert property (
    early_req && loop_depth != 3'h0 |=> loop_early_end)
    else $error("early end request not armed");

  a_early_idle: assert property (
    early_req && loop_depth == 3'h0 && !loop_early_end
      |=> !loop_early_end)
    else $error("early end armed with no loop active");

  // bus read path check
  a_read_data: assert property (
    s_arvalid && s_arready && s_araddr[3:2] == 2'h0
      |=> s_rvalid && s_rdata == {16'h0, $past(rd_word)}
      && s_rresp == 2'h0)
    else $error("register read data wrong");

  // scenario covers
  c_write_done: cover property (wr_en ##[1:4] s_bvalid && s_bready);
  c_read_done: cover property (s_arvalid && s_arready ##1 s_rvalid);
  c_early_cut: cover property (loop_early_end ##[1:8] loop_cut);
  c_depth_full: cover property (loop_depth == 3'h7);
  c_prio_raise: cover property (prio_top_set ##1 cpu_prio_level[3]);
endmodule // dcc_core_ctrl
`default_nettype wire

// ### design/dcc_loop_tracker.sv
// hardware loop nesting counter with early termination
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"
module dcc_loop_tracker
  import dcc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic loop_start,
  input wire logic loop_finish,
  input wire logic loop_iter_end,
  input wire logic early_req,
  output logic [2:0] loop_depth,
  output logic early_pending,
  output logic loop_cut
);
  logic [2:0] depth_ff;
  logic pend_ff;
  logic up, down;

  assign loop_depth = depth_ff;
  assign early_pending = pend_ff;
  // pending request ends the loop at its iteration boundary
  assign loop_cut = pend_ff && loop_iter_end;
  assign up = loop_start && depth_ff != `DCC_DEPTH_MAX;
  assign down = (loop_finish || loop_cut) && depth_ff != 3'h0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      depth_ff <= 3'h0;
    end else if (up && !down) begin
      depth_ff <= depth_ff + 3'h1;
    end else if (down && !up) begin
      depth_ff <= depth_ff - 3'h1;
    end
  end

  // a new request in the clearing cycle wins
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pend_ff <= 1'b0;
    end else if (early_req && depth_ff != 3'h0) begin
      pend_ff <= 1'b1;
    end else if (loop_iter_end) begin
      pend_ff <= 1'b0;
    end
  end
endmodule // dcc_loop_tracker
`default_nettype wire

// ### design/dcc_params.svh
// constants of the dsp core control register block
// Operation
// - top control bit set selects variable exception latency; reset gives fixed latency
// - multiply sign field 00 means signed operands, 01 unsigned; resets to signed
// - read-only three-bit field reports active hardware loops, 0 to 7
// - first accumulator saturation enable is writable and resets off
// - second accumulator saturation enable is writable, independent, resets off
// - data-space write saturation enable is writable and resets to one
// - mode bit picks super or normal saturation; reset gives normal
// - priority top bit heads cpu priority level; readable, clearable, resets zero
// - writing one to early-end bit ends current loop after this iteration
// - early-end bit always reads zero
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

`define DCC_CORE_CTRL_OFS 4'h0
`define DCC_CORE_CTRL_RST 16'h0020

`define DCC_VAR_LAT_BIT 15
`define DCC_UNUSED_BIT 14
`define DCC_MSIGN_HI 13
`define DCC_MSIGN_LO 12
`define DCC_EARLY_BIT 11
`define DCC_DEPTH_HI 10
`define DCC_DEPTH_LO 8
`define DCC_ACCUMULATOR_A_BIT 7
`define DCC_ACCUMULATOR_B_BIT 6
`define DCC_SDW_BIT 5
`define DCC_SATM_BIT 4
`define DCC_PRIO_BIT 3
`define DCC_SFA_BIT 2
`define DCC_RND_BIT 1
`define DCC_FRAC_BIT 0

`define DCC_MSIGN_SIGNED 2'h0
`define DCC_MSIGN_UNSIGNED 2'h1
`define DCC_DEPTH_MAX 3'h7

`define DCC_RESP_OKAY 2'h0
`define DCC_RESP_SLVERR 2'h2

`endif

// ### design/dcc_pkg.sv
// types shared by the dsp core control register block
`include "dcc_params.svh"

package dcc_pkg;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] strb;
  } dcc_wr_s;

  typedef struct packed {
    logic var_latency;
    logic mult_unsigned;
    logic acc_a_sat_en;
    logic acc_b_sat_en;
    logic space_write_sat_en;
    logic sat_mode_sel;
    logic rounding_sel;
    logic int_frac_sel;
  } dcc_ctrl_s;

  typedef enum logic [1:0] {
    DCC_W_COLLECT = 2'b01,
    DCC_W_RESP = 2'b10
  } dcc_wst_e;

  function automatic logic dcc_hit(input logic [3:0] addr);
    logic [3:0] ofs;
    ofs = `DCC_CORE_CTRL_OFS;
    return addr[3:2] == ofs[3:2];
  endfunction

endpackage

// ### tb/dcc_core_ctrl_tb.sv
// self-checking bench for the core control register over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module dcc_core_ctrl_tb
  import dcc_pkg::*;
;
  logic clk_sys, reset;
  logic [3:0] s_awaddr, s_araddr, s_wstrb;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic [31:0] s_wdata, s_rdata;
  logic [1:0] s_bresp, s_rresp;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic loop_start, loop_finish, loop_iter_end, prio_top_set;
  logic [2:0] prio_low_bits, loop_depth;
  logic stack_frame_active, loop_early_end, loop_cut;
  logic [3:0] cpu_prio_level;
  dcc_ctrl_s ctrl;
  int err_total, cmp_count;
  logic [1:0] rsp;
  logic [31:0] rd;

  dcc_core_ctrl dcc_core_ctrl_inst (.clk_sys(clk_sys), .reset(reset),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .loop_start(loop_start),
    .loop_finish(loop_finish), .loop_iter_end(loop_iter_end),
    .prio_top_set(prio_top_set), .prio_low_bits(prio_low_bits),
    .stack_frame_active(stack_frame_active), .ctrl(ctrl),
    .cpu_prio_level(cpu_prio_level), .loop_depth(loop_depth),
    .loop_early_end(loop_early_end), .loop_cut(loop_cut));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    err_total++;
    $display("mismatch at %0t: bus answer never came", $time);
    test_done();
  endtask

  // both halves offered together; each released at its own handshake
  task automatic axw(input logic [3:0] a, input logic [15:0] d,
                     input logic [1:0] st, output logic [1:0] resp);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_awaddr <= a;
    s_wdata <= {16'h0000, d};
    s_wstrb <= {2'b00, st};
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    for (n = 0; n < 50 && !(aw_ok && w_ok); n++) begin
      @(posedge clk_sys);
      if (!aw_ok && s_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready === 1'b1) begin
        w_ok = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    if (!(aw_ok && w_ok)) hang();
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_bvalid === 1'b1) break;
    end
    if (n == 50) hang();
    resp = s_bresp;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] resp);
    int n;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_arready === 1'b1) break;
    end
    if (n == 50) hang();
    s_arvalid <= 1'b0;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (s_rvalid === 1'b1) break;
    end
    if (n == 50) hang();
    d = s_rdata;
    resp = s_rresp;
  endtask

  task automatic pulse_wait();
    @(posedge clk_sys);
    #1;
  endtask

  initial begin
    reset = 1'b1;
    {s_awaddr, s_araddr, s_wstrb, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_arvalid} = '0;
    s_bready = 1'b1;
    s_rready = 1'b1;
    {loop_start, loop_finish, loop_iter_end, prio_top_set} = '0;
    prio_low_bits = 3'h5;
    stack_frame_active = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    pulse_wait();
    chk({24'h0, ctrl}, 32'h08);
    chk({28'h0, cpu_prio_level}, 32'h5);
    axr(4'h0, rd, rsp);
    chk(rd, 32'h0024);
    chk({30'h0, rsp}, 32'h0);
    $display("test reset done");

    axw(4'h0, 16'hffff, 2'h3, rsp);
    chk({30'h0, rsp}, 32'h0);
    axr(4'h0, rd, rsp);
    chk(rd, 32'hb0f7);
    chk({24'h0, ctrl}, 32'hbf);
    chk({31'h0, loop_early_end}, 32'h0);
    $display("test all ones done");

    for (int c = 0; c < 4; c++) begin
      axw(4'h0, {2'b00, c[1:0], 12'h000}, 2'h2, rsp);
      axr(4'h0, rd, rsp);
      chk(rd, {16'h0, 2'b00, c[1:0], 12'h0f7});
      chk({31'h0, ctrl.mult_unsigned}, {31'h0, c == 1});
    end
    $display("test sign codes done");

    for (int i = 4; i < 8; i++) begin
      axw(4'h0, 16'h0001 << i, 2'h1, rsp);
      axr(4'h0, rd, rsp);
      chk(rd, 32'h3004 | (32'h1 << i));
      chk({28'h0, ctrl[5:2]}, 32'h1 << (i - 4));
    end
    $display("test saturation bits done");

    prio_top_set <= 1'b1;
    @(posedge clk_sys);
    prio_top_set <= 1'b0;
    pulse_wait();
    chk({28'h0, cpu_prio_level}, 32'hd);
    axr(4'h0, rd, rsp);
    chk(rd, 32'h308c);
    axw(4'h0, 16'h0000, 2'h1, rsp);
    pulse_wait();
    chk({28'h0, cpu_prio_level}, 32'h5);
    $display("test priority done");

    // start one more loop than the depth field can count
    stack_frame_active <= 1'b0;
    loop_start <= 1'b1;
    repeat (8) @(posedge clk_sys);
    loop_start <= 1'b0;
    pulse_wait();
    chk({29'h0, loop_depth}, 32'h7);
    axw(4'h0, 16'h0800, 2'h2, rsp);
    pulse_wait();
    chk({31'h0, loop_early_end}, 32'h1);
    axr(4'h0, rd, rsp);
    chk(rd, 32'h0700);
    @(posedge clk_sys);
    loop_iter_end <= 1'b1;
    #1;
    chk({31'h0, loop_cut}, 32'h1);
    @(posedge clk_sys);
    loop_iter_end <= 1'b0;
    #1;
    chk({29'h0, loop_depth}, 32'h6);
    chk({31'h0, loop_early_end}, 32'h0);
    @(posedge clk_sys);
    loop_finish <= 1'b1;
    @(posedge clk_sys);
    loop_finish <= 1'b0;
    #1;
    chk({29'h0, loop_depth}, 32'h5);
    axw(4'h0, 16'h0700, 2'h2, rsp);
    axr(4'h0, rd, rsp);
    chk(rd, 32'h0500);
    $display("test loop depth done");

    axw(4'h4, 16'hffff, 2'h3, rsp);
    chk({30'h0, rsp}, 32'h2);
    axr(4'h8, rd, rsp);
    chk({rd[31:2], rsp}, 32'h2);
    axr(4'h0, rd, rsp);
    chk(rd, 32'h0500);
    $display("test unmapped done");
    test_done();
  end

  initial begin
    #200000;
    err_total++;
    $display("mismatch at %0t: run limit reached", $time);
    test_done();
  end
endmodule // dcc_core_ctrl_tb
`default_nettype wire
